//--- verilog/fbp_pkg.sv
// Purpose: shared constants and carriers for the flash block erase/protect logic
// Assumes: 64 KB array, byte addressed, 32-bit words
// Notes:   protection units pair two adjacent erase blocks
package fbp_pkg;

    // geometry
    localparam int ADDR_W      = 16;
    localparam int DATA_W      = 32;
    localparam int WORDS       = 16384;
    localparam int WORD_AW     = 14;
    localparam int BLOCK_LSB   = 10;
    localparam int UNIT_LSB    = 11;
    localparam int BLOCKS      = 64;
    localparam int UNITS       = 32;
    localparam int WORDS_PER_BLK = 256;
    localparam int BLK_WORD_AW = 8;

    // values
    localparam logic [31:0] ERASED_WORD = 32'hFFFFFFFF;
    localparam logic [31:0] BLANK_READ  = 32'h00000000;
    localparam logic [31:0] UNITS_RESET = 32'h00000000;

    // request kinds on the access port
    typedef enum logic [2:0] {
        FBP_OP_NONE   = 3'h0,
        FBP_OP_FETCH  = 3'h1,
        FBP_OP_DREAD  = 3'h3,
        FBP_OP_DBGRD  = 3'h2,
        FBP_OP_PROG   = 3'h6,
        FBP_OP_ERASE  = 3'h7
    } fbp_op_t;

    // erase sequencer states, gray along idle->run->done
    typedef enum logic [1:0] {
        FBP_ER_IDLE = 2'h0,
        FBP_ER_RUN  = 2'h1,
        FBP_ER_DONE = 2'h3
    } fbp_er_state_t;

    // one request
    typedef struct packed {
        fbp_op_t             op;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } fbp_req_t;

    // one answer
    typedef struct packed {
        logic                valid;
        logic                denied;
        logic [DATA_W-1:0]   rdata;
    } fbp_rsp_t;

endpackage : fbp_pkg

//--- verilog/fbp_unit_check.sv
// Purpose: protection decision for one request
// Assumes: protection masks are one bit per 2 KB unit
// Notes:   purely combinational
`timescale 1ns/100ps
module fbp_unit_check (
    // request
    input  wire fbp_pkg::fbp_op_t     op_in,
    input  wire logic [15:0]          addr_in,
    // protection masks
    input  wire logic [31:0]          ronly_in,
    input  wire logic [31:0]          xonly_in,
    // decision
    output logic                      allow_out
);
    logic [4:0] unit;
    logic       ro;
    logic       xo;

    // unit index from bits above 10
    assign unit = addr_in[15:fbp_pkg::UNIT_LSB];
    assign ro   = ronly_in[unit];
    assign xo   = xonly_in[unit];

    // allow matrix per request kind
    always_comb begin
        case (op_in)
            fbp_pkg::FBP_OP_FETCH: allow_out = 1'b1;
            fbp_pkg::FBP_OP_DREAD: allow_out = !xo;
            fbp_pkg::FBP_OP_DBGRD: allow_out = !xo;
            fbp_pkg::FBP_OP_PROG:  allow_out = !(ro || xo);
            fbp_pkg::FBP_OP_ERASE: allow_out = !(ro || xo);
            default:               allow_out = 1'b0;
        endcase
    end
endmodule : fbp_unit_check

//--- verilog/fbp_flash_protect.sv
// Purpose: 64 KB flash array model with block erase and unit protection
// Assumes: requests synchronous to clk_sys_in, one at a time while ready
// Notes:   reads answer on the next edge; erase walks one block word by word
// Notes on behaviour
// - the array holds 64 KB in 1 KB blocks that each erase on their own.
// - a finished erase leaves every bit of its block at one.
// - protection applies per 2 KB unit of two neighbouring blocks.
// - a unit may be read-only or execute-only, otherwise fully open.
// - program and erase into a read-only unit are refused.
// - program and erase into an execute-only unit are refused.
// - an execute-only unit returns data to instruction fetches only.
// - every read is answered one clock after it is taken.
`timescale 1ns/100ps
module fbp_flash_protect (
    // clock and reset
    input  wire logic              clk_sys_in,
    input  wire logic              reset_n_in,
    input  wire logic              clk_en_in,
    // request
    input  wire fbp_pkg::fbp_req_t req_in,
    // protection settings
    input  wire logic [31:0]       ronly_in,
    input  wire logic [31:0]       xonly_in,
    // answer
    output fbp_pkg::fbp_rsp_t      rsp_out,
    output logic                   ready_out,
    output logic                   erase_busy_out
);
    logic [31:0]                       mem [0:fbp_pkg::WORDS-1];
    fbp_pkg::fbp_rsp_t                 rsp_r;
    fbp_pkg::fbp_rsp_t                 rsp_nxt;
    fbp_pkg::fbp_er_state_t            st_r;
    fbp_pkg::fbp_er_state_t            st_nxt;
    logic [5:0]                        blk_r;
    logic [5:0]                        blk_nxt;
    logic [7:0]                        wcnt_r;
    logic [7:0]                        wcnt_nxt;
    logic                              ready_r;
    logic                              ready_nxt;
    logic                              busy_r;
    logic                              busy_nxt;
    logic                              allow;
    logic                              take;
    logic                              wr_en;
    logic [fbp_pkg::WORD_AW-1:0]       wr_addr;
    logic [31:0]                       wr_data;
    logic [fbp_pkg::WORD_AW-1:0]       rd_addr;

    // protection decision
    fbp_unit_check u_check (
        .op_in     (req_in.op),
        .addr_in   (req_in.addr),
        .ronly_in  (ronly_in),
        .xonly_in  (xonly_in),
        .allow_out (allow)
    );

    assign take    = ready_r && (req_in.op != fbp_pkg::FBP_OP_NONE);
    assign rd_addr = req_in.addr[15:2];

    // request decode and erase start
    logic                              is_read;
    logic                              is_prog;
    logic                              is_erase;
    logic                              erase_go;
    logic                              seq_last;

    // request kind decode, unknown codes get no answer
    always_comb begin
        is_read  = 1'b0;
        is_prog  = 1'b0;
        is_erase = 1'b0;
        case (req_in.op)
            fbp_pkg::FBP_OP_FETCH,
            fbp_pkg::FBP_OP_DREAD,
            fbp_pkg::FBP_OP_DBGRD: begin
                is_read = 1'b1;
            end
            fbp_pkg::FBP_OP_PROG: begin
                is_prog = 1'b1;
            end
            fbp_pkg::FBP_OP_ERASE: begin
                is_erase = 1'b1;
            end
            default: begin
                is_read = 1'b0;
            end
        endcase
    end

    // an erase only starts when its unit allows it
    assign erase_go = take && is_erase && allow;
    // last word of the block is written this cycle
    assign seq_last = (st_r == fbp_pkg::FBP_ER_RUN)
                   && (wcnt_r == 8'(fbp_pkg::WORDS_PER_BLK - 1));

    // erase sequencer next state
    always_comb begin
        st_nxt   = st_r;
        blk_nxt  = blk_r;
        wcnt_nxt = wcnt_r;
        case (st_r)
            fbp_pkg::FBP_ER_IDLE: begin
                if (erase_go) begin
                    st_nxt   = fbp_pkg::FBP_ER_RUN;
                    blk_nxt  = req_in.addr[15:fbp_pkg::BLOCK_LSB];
                    wcnt_nxt = 8'h00;
                end
            end
            fbp_pkg::FBP_ER_RUN: begin
                // one word of the block per cycle
                wcnt_nxt = wcnt_r + 8'h01;
                if (seq_last) begin
                    st_nxt = fbp_pkg::FBP_ER_DONE;
                end
            end
            fbp_pkg::FBP_ER_DONE: begin
                st_nxt = fbp_pkg::FBP_ER_IDLE;
            end
            default: begin
                st_nxt = fbp_pkg::FBP_ER_IDLE;
            end
        endcase
    end

    // erase sequencer registers
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_r   <= fbp_pkg::FBP_ER_IDLE;
            blk_r  <= 6'h00;
            wcnt_r <= 8'h00;
        end else if (clk_en_in) begin
            st_r   <= st_nxt;
            blk_r  <= blk_nxt;
            wcnt_r <= wcnt_nxt;
        end
    end

    // ready drops for the whole erase so no request slips in
    always_comb begin
        ready_nxt = ready_r;
        if (erase_go) begin
            ready_nxt = 1'b0;
        end else if (st_r == fbp_pkg::FBP_ER_DONE) begin
            ready_nxt = 1'b1;
        end
    end

    // ready register, high out of reset
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ready_r <= 1'b1;
        end else if (clk_en_in) begin
            ready_r <= ready_nxt;
        end
    end

    // busy flag covers the erase walk and its closing cycle
    always_comb begin
        busy_nxt = busy_r;
        if (erase_go) begin
            busy_nxt = 1'b1;
        end else if (st_r == fbp_pkg::FBP_ER_DONE) begin
            busy_nxt = 1'b0;
        end
    end

    // busy register
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            busy_r <= 1'b0;
        end else if (clk_en_in) begin
            busy_r <= busy_nxt;
        end
    end

    // answer of a taken request, or the close of an erase
    always_comb begin
        rsp_nxt = '0;
        if (take && (is_read || is_prog || is_erase)) begin
            rsp_nxt.valid  = !erase_go;           // accepted erase answers at its end
            rsp_nxt.denied = !allow;
            if (is_read && allow) begin
                rsp_nxt.rdata = mem[rd_addr];
            end else begin
                rsp_nxt.rdata = fbp_pkg::BLANK_READ;
            end
        end else if (st_r == fbp_pkg::FBP_ER_DONE) begin
            rsp_nxt.valid = 1'b1;
        end
    end

    // answer register, a one-cycle pulse
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rsp_r <= '0;
        end else if (clk_en_in) begin
            rsp_r <= rsp_nxt;
        end
    end

    // array write select: the erase walk, or one program word
    always_comb begin
        wr_en   = 1'b0;
        wr_addr = rd_addr;
        wr_data = req_in.wdata;
        if (st_r == fbp_pkg::FBP_ER_RUN) begin
            wr_en   = 1'b1;
            wr_addr = {blk_r, wcnt_r};
            wr_data = fbp_pkg::ERASED_WORD;
        end else if (take && is_prog) begin
            wr_en = allow;
        end
    end

    // array write port, no reset on storage
    always_ff @(posedge clk_sys_in) begin
        if (clk_en_in && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    assign rsp_out        = rsp_r;
    assign ready_out      = ready_r;
    assign erase_busy_out = busy_r;
endmodule : fbp_flash_protect

//--- dv/fbp_chk_sva.sv
// Purpose: port checks for the flash protect block
// Assumes: requests only count on enabled edges
// Notes:   bound onto fbp_flash_protect below
`timescale 1ns/100ps
module fbp_chk (
    // watched ports
    input wire logic              clk_sys_in,
    input wire logic              reset_n_in,
    input wire logic              clk_en_in,
    input wire fbp_pkg::fbp_req_t req_in,
    input wire logic [31:0]       ronly_in,
    input wire logic [31:0]       xonly_in,
    input wire fbp_pkg::fbp_rsp_t rsp_out,
    input wire logic              ready_out,
    input wire logic              erase_busy_out
);
    // decoded request
    logic tk, rd, wr, er, fe, ro, xo;
    assign tk = clk_en_in && ready_out && req_in.op != fbp_pkg::FBP_OP_NONE;
    assign rd = req_in.op inside {fbp_pkg::FBP_OP_DREAD, fbp_pkg::FBP_OP_DBGRD};
    assign wr = req_in.op[2];
    assign er = req_in.op == fbp_pkg::FBP_OP_ERASE;
    assign fe = req_in.op == fbp_pkg::FBP_OP_FETCH;
    assign ro = ronly_in[req_in.addr[15:11]];
    assign xo = xonly_in[req_in.addr[15:11]];
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    a_read_one_cycle: assert property (tk && !wr |=> rsp_out.valid)
        else $error("read answer late");
    a_ronly_no_write: assert property (tk && wr && ro |=> rsp_out.valid && rsp_out.denied)
        else $error("write into read-only unit taken");
    a_xonly_no_write: assert property (tk && wr && xo |=> rsp_out.denied)
        else $error("write into execute-only unit taken");
    a_xonly_no_read: assert property (tk && rd && xo |=> rsp_out.denied && rsp_out.rdata == 32'h0)
        else $error("data read of execute-only unit served");
    a_fetch_served: assert property (tk && fe |=> !rsp_out.denied)
        else $error("fetch refused");
    a_open_unit_ok: assert property (tk && !ro && !xo |=> !rsp_out.denied)
        else $error("open unit refused");
    a_erase_busy_hold: assert property (tk && er && !ro && !xo |=> (!ready_out && erase_busy_out)[*8])
        else $error("erase not busy");
    a_erase_done_time: assert property (tk && er && !ro && !xo |-> ##258 rsp_out.valid)
        else $error("erase end mistimed");
    a_valid_has_cause: assert property (rsp_out.valid |-> $past(tk) || $fell(erase_busy_out))
        else $error("answer without request");
endmodule : fbp_chk
bind fbp_flash_protect fbp_chk i_chk (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .clk_en_in(clk_en_in), .req_in(req_in), .ronly_in(ronly_in), .xonly_in(xonly_in),
    .rsp_out(rsp_out), .ready_out(ready_out), .erase_busy_out(erase_busy_out));

//--- dv/fbp_req_model.sv
// Purpose: requester model for core buses and debugger
// Assumes: one request in flight, held until taken
// Notes:   released data lines show the inverted last value
`timescale 1ns/100ps
module fbp_req_model (
    // clock and handshake
    input  wire logic         clk_sys_in,
    input  wire logic         ready_in,
    // request
    output fbp_pkg::fbp_req_t req_out
);
    initial req_out = '0;
    // hold the request until an edge sees ready high
    task automatic issue(input fbp_pkg::fbp_op_t op, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        req_out <= '{op, a, d};
        @(negedge clk_sys_in);
        while (!ready_in) @(negedge clk_sys_in);
        @(posedge clk_sys_in);
        req_out <= '{fbp_pkg::FBP_OP_NONE, ~a, ~d};
    endtask : issue
endmodule : fbp_req_model

//--- dv/tb_fbp_flash_protect.sv
// Purpose: self-checking bench for the flash protect block
// Assumes: clock enable held high except in t_freeze
// Notes:   requests go through the requester model
`timescale 1ns/100ps
module tb_fbp_flash_protect;
    logic              clk_sys_in, reset_n_in, ready, busy, clk_en;
    logic [31:0]       ronly, xonly;
    fbp_pkg::fbp_req_t req;
    fbp_pkg::fbp_rsp_t rsp;
    int                error_cnt, checks_done;
    fbp_req_model i_req (.clk_sys_in(clk_sys_in), .ready_in(ready), .req_out(req));
    fbp_flash_protect i_dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en),
        .req_in(req), .ronly_in(ronly), .xonly_in(xonly), .rsp_out(rsp), .ready_out(ready),
        .erase_busy_out(busy));
    // clock
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // one access; answer and cycles until it
    task automatic acc(input fbp_pkg::fbp_op_t op, input logic [15:0] a, input logic [31:0] d,
                       output logic [1:0] dv, output logic [31:0] q, output int n);
        i_req.issue(op, a, d);
        n = 0;
        do begin @(negedge clk_sys_in); n++; end while (rsp.valid !== 1'b1 && n < 400);
        dv = {rsp.valid, rsp.denied};
        q = rsp.rdata;
    endtask : acc
    task automatic wr(input logic e, input logic [15:0] a, input logic [31:0] d, input logic den);
        logic [1:0] dv;
        logic [31:0] q;
        int n;
        acc(e ? fbp_pkg::FBP_OP_ERASE : fbp_pkg::FBP_OP_PROG, a, d, dv, q, n);
        chk("write denied", dv, {1'b1, den});
    endtask : wr
    task automatic rd(input fbp_pkg::fbp_op_t op, input logic [15:0] a, input logic [31:0] x,
                      input logic den);
        logic [1:0] dv;
        logic [31:0] q;
        int n;
        acc(op, a, 32'h0, dv, q, n);
        chk("read cycles", n, 1);
        chk("read denied", dv, {1'b1, den});
        chk("read data", q, x);
    endtask : rd
    task automatic t_open();
        @(negedge clk_sys_in);
        chk("idle after reset", {ready, busy, rsp.valid}, 3'b100);
        wr(0, 16'h0800, 32'hA5A50001, 0);
        wr(0, 16'h0C04, 32'h5A5A0002, 0);
        wr(0, 16'h1000, 32'h3C3C0003, 0);
        rd(fbp_pkg::FBP_OP_DREAD, 16'h0800, 32'hA5A50001, 0);
        rd(fbp_pkg::FBP_OP_DBGRD, 16'h0C04, 32'h5A5A0002, 0);
        rd(fbp_pkg::FBP_OP_FETCH, 16'h1000, 32'h3C3C0003, 0);
        $display("done t_open");
    endtask : t_open
    task automatic t_erase();
        logic [1:0] dv;
        logic [31:0] q;
        int n;
        fork
            acc(fbp_pkg::FBP_OP_ERASE, 16'h0C00, 32'h0, dv, q, n);
            begin
                repeat (2) @(negedge clk_sys_in);
                chk("erase running", {ready, busy}, 2'b01);
            end
        join
        chk("erase cycles", n, 258);
        chk("erase ends", {ready, busy}, 2'b10);
        rd(fbp_pkg::FBP_OP_DREAD, 16'h0C04, 32'hFFFFFFFF, 0);
        rd(fbp_pkg::FBP_OP_DREAD, 16'h0FFC, 32'hFFFFFFFF, 0);
        rd(fbp_pkg::FBP_OP_DREAD, 16'h0800, 32'hA5A50001, 0);
        $display("done t_erase");
    endtask : t_erase
    task automatic t_prot();
        @(posedge clk_sys_in);
        ronly <= 32'h2;
        xonly <= 32'h4;
        wr(0, 16'h0800, 32'h11112222, 1);
        wr(1, 16'h0C00, 32'h0, 1);
        rd(fbp_pkg::FBP_OP_DREAD, 16'h0800, 32'hA5A50001, 0);
        wr(0, 16'h1000, 32'h33334444, 1);
        wr(1, 16'h1400, 32'h0, 1);
        rd(fbp_pkg::FBP_OP_DREAD, 16'h17FC, 32'h0, 1);
        rd(fbp_pkg::FBP_OP_DBGRD, 16'h1000, 32'h0, 1);
        rd(fbp_pkg::FBP_OP_FETCH, 16'h1000, 32'h3C3C0003, 0);
        wr(0, 16'h1800, 32'h55556666, 0);
        rd(fbp_pkg::FBP_OP_DBGRD, 16'h1800, 32'h55556666, 0);
        $display("done t_prot");
    endtask : t_prot
    // a program while the clock enable is low must leave no trace
    task automatic t_freeze();
        @(posedge clk_sys_in);
        clk_en <= 1'b0;
        i_req.issue(fbp_pkg::FBP_OP_PROG, 16'h1800, 32'h77778888);
        repeat (3) begin
            @(negedge clk_sys_in);
            chk("frozen answer", {ready, busy, rsp.valid}, 3'b100);
        end
        @(posedge clk_sys_in);
        clk_en <= 1'b1;
        rd(fbp_pkg::FBP_OP_DBGRD, 16'h1800, 32'h55556666, 0);
        $display("done t_freeze");
    endtask : t_freeze
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    // main sequence
    initial begin
        reset_n_in = 1'b0;
        ronly = 32'h0;
        xonly = 32'h0;
        clk_en = 1'b1;
        error_cnt = 0;
        checks_done = 0;
        repeat (16) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        t_open();
        t_erase();
        t_prot();
        t_freeze();
        wrap_up();
    end
    // watchdog
    initial begin
        #200000;
        error_cnt++;
        wrap_up();
    end
endmodule : tb_fbp_flash_protect
